// File: core/apc_pin_ctrl.sv
// analog pin control registers, pin override and sample/result logic of the converter
// assumes a plain register port: one-cycle strobes, read data one cycle later; inputs synchronous to ref_clk
//
// Summary of operation
// - upper register governs channels eight through fifteen
// - bit 7 is channel 15, down to bit 0 for channel 8
// - bit clear keeps digital I/O, set disables
// - conversions run regardless of pin-control bits
// - set bit: output tri-stated, pullup off
// - at or above high reference gives full scale
// - at or below low reference gives zero
// - sample lasts 3.5 or 23.5 conversion clocks
// - lower register: same encoding for channels 0-7
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "apc_defines.svh"
module apc_pin_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire apc_pkg::apc_addr_type reg_addr,
  input wire apc_pkg::apc_data_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output apc_pkg::apc_data_type reg_rdata,
  input wire logic [15:0] port_dir_out,
  input wire logic [15:0] port_pullup_en,
  input wire logic [15:0] port_data_out,
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  output logic [15:0] pin_pullup,
  output logic [15:0] pin_in_buf_en,
  output logic [15:0] port_data_in,
  input wire apc_pkg::apc_code_type ain_code,
  input wire logic ain_at_high,
  input wire logic ain_at_low,
  output logic [3:0] sample_chan,
  output logic sample_active,
  output logic conversion_clock,
  output apc_pkg::apc_code_type conv_result,
  output logic conv_done
);
  import apc_pkg::*;

  logic [7:0] analog_pin_ctrl_low;
  logic [7:0] analog_pin_ctrl_high;
  logic long_sample_select;
  logic mode8;
  logic [3:0] chan_sel;
  logic done_flag;
  logic [15:0] pin_disable;
  logic wr_low;
  logic wr_high;
  logic wr_conv;
  logic wr_stat;
  logic start_req;
  apc_data_type next_rdata;
  apc_code_type next_result;

  apc_sample_if sif ();

  assign wr_low = reg_wr && reg_addr == `APC_ADDR_PIN_LOW;
  assign wr_high = reg_wr && reg_addr == `APC_ADDR_PIN_HIGH;
  assign wr_conv = reg_wr && reg_addr == `APC_ADDR_CONV;
  assign wr_stat = reg_wr && reg_addr == `APC_ADDR_STAT;
  assign start_req = wr_conv && reg_wdata[`APC_CONV_START];

  // channel n of 16 sits at bit n of the concatenation
  assign pin_disable = {analog_pin_ctrl_high, analog_pin_ctrl_low};

  // pin-control registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      analog_pin_ctrl_low <= `APC_PIN_RESET;
      analog_pin_ctrl_high <= `APC_PIN_RESET;
    end else if (ce) begin
      if (wr_low) begin
        analog_pin_ctrl_low <= reg_wdata[7:0];
      end
      if (wr_high) begin
        analog_pin_ctrl_high <= reg_wdata[7:0];
      end
    end
  end

  // conversion control register; start is a strobe, not stored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      long_sample_select <= 1'b0;
      mode8 <= 1'b0;
      chan_sel <= `APC_CHAN_RESET;
    end else if (ce && wr_conv) begin
      long_sample_select <= reg_wdata[`APC_CONV_LONG];
      mode8 <= reg_wdata[`APC_CONV_MODE8];
      chan_sel <= reg_wdata[`APC_CONV_CHAN_HI:`APC_CONV_CHAN_LO];
    end
  end

  // pin-control bits are not consulted here: any channel may be sampled
  assign sif.start = ce && start_req;
  assign sif.long_sel = wr_conv ? reg_wdata[`APC_CONV_LONG] : long_sample_select;

  apc_sample_timer u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .sif(sif)
  );

  // result coding at the reference limits
  always_comb begin
    if (ain_at_high) begin
      next_result = mode8 ? `APC_FULL8 : `APC_FULL10;
    end else if (ain_at_low) begin
      next_result = `APC_ZERO_CODE;
    end else if (mode8) begin
      next_result = {2'b00, ain_code[9:2]};
    end else begin
      next_result = ain_code;
    end
  end

  // result and done flag; a new done wins over a software clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      conv_result <= `APC_RESULT_RESET;
      done_flag <= 1'b0;
      conv_done <= 1'b0;
    end else if (ce) begin
      conv_done <= sif.done;
      if (sif.done) begin
        conv_result <= next_result;
      end
      if (sif.done) begin
        done_flag <= 1'b1;
      end else if (wr_stat && reg_wdata[`APC_STAT_DONE]) begin
        done_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sample_active <= 1'b0;
      conversion_clock <= 1'b0;
      sample_chan <= `APC_CHAN_RESET;
    end else if (ce) begin
      sample_active <= sif.busy;
      conversion_clock <= sif.conv_clk;
      sample_chan <= chan_sel;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = `APC_DATA_ZERO;
    case (reg_addr)
      `APC_ADDR_PIN_LOW: next_rdata = {`APC_BYTE_ZERO, analog_pin_ctrl_low};
      `APC_ADDR_PIN_HIGH: next_rdata = {`APC_BYTE_ZERO, analog_pin_ctrl_high};
      `APC_ADDR_CONV: next_rdata = {`APC_BYTE_ZERO, chan_sel, 2'b00, mode8, long_sample_select};
      `APC_ADDR_STAT: next_rdata = {14'h0000, done_flag, sif.busy};
      `APC_ADDR_RESULT: next_rdata = {`APC_RES_PAD, conv_result};
      default: next_rdata = `APC_DATA_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= `APC_DATA_ZERO;
    end else if (ce) begin
      reg_rdata <= reg_rd ? next_rdata : `APC_DATA_ZERO;
    end
  end

  // per-pin override of the port logic, registered so every output leaves a flop
  for (genvar i = 0; i < 16; i++) begin : g_pin
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        pin_oe[i] <= 1'b0;
        pin_out[i] <= 1'b0;
        pin_pullup[i] <= 1'b0;
        pin_in_buf_en[i] <= 1'b1;
        port_data_in[i] <= 1'b0;
      end else if (ce) begin
        // analog use wins over direction and pullup; input buffer off saves dc current
        pin_oe[i] <= !pin_disable[i] && port_dir_out[i];
        pin_out[i] <= port_data_out[i];
        pin_pullup[i] <= !pin_disable[i] && port_pullup_en[i] && !port_dir_out[i];
        pin_in_buf_en[i] <= !pin_disable[i];
        if (pin_disable[i]) begin
          port_data_in[i] <= 1'b0;
        end else begin
          port_data_in[i] <= port_dir_out[i] ? port_data_out[i] : pin_in[i];
        end
      end
    end
  end

  sequence s_write_high;
    ce && wr_high;
  endsequence

  property p_high_readback;
    @(posedge ref_clk) disable iff (!rst_n)
      (ce && reg_rd && reg_addr == `APC_ADDR_PIN_HIGH) |=> reg_rdata == {`APC_BYTE_ZERO, $past(analog_pin_ctrl_high)};
  endproperty
  a_high_readback: assert property (p_high_readback) else $error("upper pin register readback wrong");

  property p_reset_clear;
    @(posedge ref_clk) (!rst_n) |=> analog_pin_ctrl_high == `APC_PIN_RESET && analog_pin_ctrl_low == `APC_PIN_RESET;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("pin registers not cleared by reset");

  property p_chan15_map;
    @(posedge ref_clk) disable iff (!rst_n)
      (s_write_high and reg_wdata[7]) ##1 ce |=> !pin_oe[15] && !pin_pullup[15];
  endproperty
  a_chan15_map: assert property (p_chan15_map) else $error("bit 7 does not control channel 15");

  property p_chan10_map;
    @(posedge ref_clk) disable iff (!rst_n)
      (s_write_high and reg_wdata[2]) ##1 ce |=> !pin_in_buf_en[10];
  endproperty
  a_chan10_map: assert property (p_chan10_map) else $error("bit 2 does not control channel 10");

  property p_enabled_follows_port;
    @(posedge ref_clk) disable iff (!rst_n)
      (ce && !pin_disable[3]) |=> pin_oe[3] == $past(port_dir_out[3]) && pin_in_buf_en[3];
  endproperty
  a_enabled_follows_port: assert property (p_enabled_follows_port) else $error("enabled pin ignores port");

  property p_disabled_hiz;
    @(posedge ref_clk) disable iff (!rst_n)
      (ce && pin_disable != 16'h0000) |=> (pin_oe & $past(pin_disable)) == 16'h0000
        && (pin_pullup & $past(pin_disable)) == 16'h0000;
  endproperty
  a_disabled_hiz: assert property (p_disabled_hiz) else $error("disabled pin still driven or pulled up");

  property p_low_map;
    @(posedge ref_clk) disable iff (!rst_n)
      (ce && analog_pin_ctrl_low[1] && port_dir_out[1]) |=> !pin_oe[1];
  endproperty
  a_low_map: assert property (p_low_map) else $error("bit 1 does not control channel 1");

  property p_start_any_pin;
    @(posedge ref_clk) disable iff (!rst_n)
      (ce && start_req && !sif.busy) |=> sif.busy ##1 (sample_active || !ce);
  endproperty
  a_start_any_pin: assert property (p_start_any_pin) else $error("conversion did not start");

  property p_full_scale;
    @(posedge ref_clk) disable iff (!rst_n)
      (ce && sif.done && ain_at_high) |=> conv_result == ($past(mode8) ? `APC_FULL8 : `APC_FULL10) && conv_done;
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("full scale code wrong");

  property p_zero_scale;
    @(posedge ref_clk) disable iff (!rst_n)
      (ce && sif.done && !ain_at_high && ain_at_low) |=> conv_result == `APC_ZERO_CODE;
  endproperty
  a_zero_scale: assert property (p_zero_scale) else $error("low reference code not zero");

  property p_linear;
    @(posedge ref_clk) disable iff (!rst_n)
      (ce && sif.done && !ain_at_high && !ain_at_low && !mode8) |=> conv_result == $past(ain_code);
  endproperty
  a_linear: assert property (p_linear) else $error("linear code not passed");
endmodule // apc_pin_ctrl

// File: core/apc_sample_timer.sv
// sample phase timer: runs the conversion clock and times the sample window
// assumes start is one cycle long and only honoured while idle
`timescale 1ns/10ps
`include "apc_defines.svh"
module apc_sample_timer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  apc_sample_if.timer sif
);
  import apc_pkg::*;

  apc_state_type state;
  logic [3:0] div;
  logic [5:0] halves;
  logic [5:0] target;
  logic tick;
  logic [7:0] elapsed;

  assign tick = (div == `APC_HALF_PER - 4'h1);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= APC_IDLE;
      div <= `APC_DIV_ZERO;
      halves <= `APC_HALVES_ZERO;
      target <= `APC_HALVES_SHORT;
      sif.busy <= 1'b0;
      sif.done <= 1'b0;
      sif.conv_clk <= 1'b0;
    end else if (ce) begin
      sif.done <= 1'b0;
      case (state)
        APC_IDLE: begin
          if (sif.start) begin
            state <= APC_SAMPLE;
            div <= `APC_DIV_ZERO;
            halves <= `APC_HALVES_ZERO;
            target <= sif.long_sel ? `APC_HALVES_LONG : `APC_HALVES_SHORT;
            sif.busy <= 1'b1;
            sif.conv_clk <= 1'b1;
          end
        end
        APC_SAMPLE: begin
          div <= tick ? `APC_DIV_ZERO : div + 4'h1;
          if (tick) begin
            halves <= halves + `APC_HALVES_ONE;
            sif.conv_clk <= ~sif.conv_clk;
            // odd half count gives the half cycle of the window
            if (halves == target - `APC_HALVES_ONE) begin
              state <= APC_IDLE;
              sif.busy <= 1'b0;
              sif.done <= 1'b1;
              sif.conv_clk <= 1'b0;
            end
          end
        end
        default: begin
          state <= APC_IDLE;
          sif.busy <= 1'b0;
        end
      endcase
    end
  end

  // helper: enabled cycles spent sampling
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      elapsed <= 8'h00;
    end else if (ce) begin
      if (state == APC_IDLE) begin
        elapsed <= 8'h01;
      end else begin
        elapsed <= elapsed + 8'h01;
      end
    end
  end

  sequence s_accept;
    ce && state == APC_IDLE && sif.start;
  endsequence

  property p_sample_len;
    @(posedge ref_clk) disable iff (!rst_n)
      (ce && state == APC_SAMPLE && tick && halves == target - `APC_HALVES_ONE)
      |-> elapsed == 8'(target) * 8'(`APC_HALF_PER);
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample window length wrong");

  property p_short_target;
    @(posedge ref_clk) disable iff (!rst_n)
      (s_accept and (ce && !sif.long_sel)) |=> target == `APC_HALVES_SHORT && sif.busy;
  endproperty
  a_short_target: assert property (p_short_target) else $error("short sample not 7 halves");

  property p_long_target;
    @(posedge ref_clk) disable iff (!rst_n)
      (s_accept and (ce && sif.long_sel)) |=> target == `APC_HALVES_LONG && sif.busy;
  endproperty
  a_long_target: assert property (p_long_target) else $error("long sample not 47 halves");
endmodule // apc_sample_timer

// File: pkg/apc_defines.svh
// register map, field positions, reset values and timing counts of the analog pin control block
// assumes inclusion by every design file that decodes registers or counts sample time
`ifndef APC_DEFINES_SVH
`define APC_DEFINES_SVH

`define APC_ADDR_PIN_LOW 8'h00
`define APC_ADDR_PIN_HIGH 8'h04
`define APC_ADDR_CONV 8'h08
`define APC_ADDR_STAT 8'h0C
`define APC_ADDR_RESULT 8'h10

`define APC_CONV_LONG 0
`define APC_CONV_MODE8 1
`define APC_CONV_START 2
`define APC_CONV_CHAN_LO 4
`define APC_CONV_CHAN_HI 7

`define APC_STAT_BUSY 0
`define APC_STAT_DONE 1

`define APC_PIN_RESET 8'h00
`define APC_CONV_RESET 4'h0
`define APC_CHAN_RESET 4'h0
`define APC_RESULT_RESET 10'h000
`define APC_DATA_ZERO 16'h0000
`define APC_BYTE_ZERO 8'h00
`define APC_RES_PAD 6'h00

`define APC_FULL10 10'h3FF
`define APC_FULL8 10'h0FF
`define APC_ZERO_CODE 10'h000

// conversion clock half period, in ref_clk cycles
`define APC_HALF_PER 4'h2
`define APC_DIV_ZERO 4'h0
// sample phase in conversion-clock half periods: 3.5 and 23.5 cycles
`define APC_HALVES_SHORT 6'h07
`define APC_HALVES_LONG 6'h2F
`define APC_HALVES_ZERO 6'h00
`define APC_HALVES_ONE 6'h01

`endif

// File: pkg/apc_pkg.sv
// types shared by the analog pin control block and its sample timer
// assumes the defines header carries every number
package apc_pkg;
  typedef logic [7:0] apc_addr_type;
  typedef logic [15:0] apc_data_type;
  typedef logic [9:0] apc_code_type;
  typedef enum logic {
    APC_IDLE = 1'b0,
    APC_SAMPLE = 1'b1
  } apc_state_type;
endpackage

// File: pkg/apc_sample_if.sv
// carrier between the register side and the sample timer
// assumes both ends run on the same ref_clk
`timescale 1ns/10ps
interface apc_sample_if;
  logic start;
  logic long_sel;
  logic busy;
  logic done;
  logic conv_clk;
  modport timer (input start, input long_sel, output busy, output done, output conv_clk);
  modport ctrl (output start, output long_sel, input busy, input done, input conv_clk);
endinterface

// File: tb/apc_pin_ctrl_test.sv
// self-checking bench for the analog pin control block: registers, pin override, sample timing, result codes
// assumes the defines header is on the include path and the design asserts its own timing internally
`timescale 1ns/10ps
`include "apc_defines.svh"
module apc_pin_ctrl_test;
  import apc_pkg::*;
  logic ref_clk, rst_n, ce, reg_wr, reg_rd;
  apc_addr_type reg_addr;
  apc_data_type reg_wdata, reg_rdata, rd_val;
  logic [15:0] port_dir_out, port_pullup_en, port_data_out, pin_in;
  logic [15:0] pin_out, pin_oe, pin_pullup, pin_in_buf_en, port_data_in;
  apc_code_type ain_code, conv_result;
  logic ain_at_high, ain_at_low, sample_active, conversion_clock, conv_done;
  logic [3:0] sample_chan;
  logic [31:0] seed;
  int n_fail, tests_run;

  apc_pin_ctrl u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_dir_out(port_dir_out),
    .port_pullup_en(port_pullup_en), .port_data_out(port_data_out), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_in_buf_en(pin_in_buf_en),
    .port_data_in(port_data_in), .ain_code(ain_code), .ain_at_high(ain_at_high),
    .ain_at_low(ain_at_low), .sample_chan(sample_chan), .sample_active(sample_active),
    .conversion_clock(conversion_clock), .conv_result(conv_result), .conv_done(conv_done)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] next_lfsr(logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  // expected code: reference limits win over the linear code, high before low
  function automatic apc_code_type exp_code(logic hi, logic lo, logic m8, apc_code_type c);
    if (hi) return m8 ? `APC_FULL8 : `APC_FULL10;
    if (lo) return `APC_ZERO_CODE;
    return m8 ? {2'b00, c[9:2]} : c;
  endfunction

  task automatic chk16(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk10(string what, apc_code_type exp, apc_code_type got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_cnt(string what, int exp, int got);
    tests_run++;
    if (got != exp) begin
      n_fail++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wr(apc_addr_type a, apc_data_type d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(apc_addr_type a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  task automatic check_pins(logic [15:0] dis);
    repeat (3) @(posedge ref_clk);
    #1;
    chk16("pin_oe", port_dir_out & ~dis, pin_oe);
    chk16("pin_pullup", port_pullup_en & ~port_dir_out & ~dis, pin_pullup);
    chk16("pin_in_buf_en", ~dis, pin_in_buf_en);
    chk16("port_data_in", ~dis & ((port_dir_out & port_data_out) | (~port_dir_out & pin_in)), port_data_in);
    chk16("pin_out", port_data_out, pin_out);
  endtask

  task automatic conv(logic lng, logic m8, logic [3:0] ch, logic hi, logic lo, apc_code_type c);
    int n;
    int n_act;
    int n_rise;
    logic prev_clk;
    @(posedge ref_clk);
    ain_code <= c;
    ain_at_high <= hi;
    ain_at_low <= lo;
    wr(`APC_ADDR_CONV, {8'h00, ch, 1'b0, 1'b1, m8, lng});
    n = 0;
    n_act = 0;
    n_rise = 0;
    prev_clk = 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
      #1;
      if (sample_active === 1'b1) begin
        n_act++;
      end
      if (conversion_clock === 1'b1 && prev_clk === 1'b0) begin
        n_rise++;
      end
      prev_clk = conversion_clock;
    end while (conv_done !== 1'b1 && n < 200);
    chk_cnt("done delay", lng ? 95 : 15, n);
    chk_cnt("sample_active cycles", lng ? 94 : 14, n_act);
    // 3.5 or 23.5 conversion clocks: 4 or 24 high phases, then idle low
    chk_cnt("conversion_clock rises", lng ? 24 : 4, n_rise);
    chk16("conversion_clock idle", 16'h0000, {15'h0000, conversion_clock});
    chk10("conv_result", exp_code(hi, lo, m8, c), conv_result);
    chk16("sample_chan", {12'h000, ch}, {12'h000, sample_chan});
    @(posedge ref_clk);
    #1;
    chk16("conv_done pulse", 16'h0000, {15'h0000, conv_done});
    n = 0;
    do begin
      rd(`APC_ADDR_STAT);
      n++;
    end while (rd_val[`APC_STAT_BUSY] !== 1'b0 && n < 10);
    chk16("status done", 16'h0002, rd_val);
    wr(`APC_ADDR_STAT, 16'h0002);
    rd(`APC_ADDR_RESULT);
    chk16("result register", {6'h00, exp_code(hi, lo, m8, c)}, rd_val);
    rd(`APC_ADDR_STAT);
    chk16("status cleared", `APC_DATA_ZERO, rd_val);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // cut a hang well past the fewer than two thousand cycles the sequence needs
  initial begin
    repeat (50000) @(posedge ref_clk);
    n_fail++;
    results();
  end

  initial begin
    logic [7:0] hi_val, lo_val;
    logic [7:0] corner [4];
    corner = '{8'hFF, 8'h00, 8'h80, 8'h04};
    n_fail = 0;
    tests_run = 0;
    seed = 32'hfae1502a;
    rst_n = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = `APC_BYTE_ZERO;
    reg_wdata = `APC_DATA_ZERO;
    port_dir_out = 16'hFFFF;
    port_pullup_en = 16'hFFFF;
    port_data_out = 16'hA5A5;
    pin_in = 16'h5A5A;
    ain_code = `APC_ZERO_CODE;
    ain_at_high = 1'b0;
    ain_at_low = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk16("buf_en after reset", 16'hFFFF, pin_in_buf_en);
    rd(`APC_ADDR_PIN_HIGH);
    chk16("upper reset", `APC_DATA_ZERO, rd_val);
    for (int i = 0; i < 34; i++) begin
      @(posedge ref_clk);
      seed = next_lfsr(seed);
      hi_val = (i < 4) ? corner[i] : seed[7:0];
      lo_val = seed[15:8];
      port_dir_out <= seed[31:16];
      seed = next_lfsr(seed);
      port_pullup_en <= seed[15:0];
      port_data_out <= seed[31:16];
      seed = next_lfsr(seed);
      pin_in <= seed[15:0];
      wr(`APC_ADDR_PIN_HIGH, {seed[31:24], hi_val});
      wr(`APC_ADDR_PIN_LOW, {8'h00, lo_val});
      // unmapped write must not alias onto either pin register
      wr(8'h1C, 16'hFFFF);
      rd(`APC_ADDR_PIN_HIGH);
      chk16("upper readback", {8'h00, hi_val}, rd_val);
      rd(`APC_ADDR_PIN_LOW);
      chk16("lower readback", {8'h00, lo_val}, rd_val);
      check_pins({hi_val, lo_val});
    end
    rd(8'h1C);
    chk16("unmapped read", `APC_DATA_ZERO, rd_val);
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(`APC_ADDR_PIN_HIGH, 16'h005A);
    ce <= 1'b1;
    rd(`APC_ADDR_PIN_HIGH);
    chk16("write with ce low", {8'h00, hi_val}, rd_val);
    // pin bits clear: conversions still run, on twelve randomly drawn channels
    wr(`APC_ADDR_PIN_HIGH, `APC_DATA_ZERO);
    wr(`APC_ADDR_PIN_LOW, `APC_DATA_ZERO);
    for (int k = 0; k < 12; k++) begin
      seed = next_lfsr(seed);
      conv(k[0], k[1], seed[3:0], k[3:2] == 2'd1, k[3:2] == 2'd2, seed[13:4]);
    end
    // software marks channel 15 analog before converting it
    wr(`APC_ADDR_PIN_HIGH, 16'h0080);
    conv(1'b0, 1'b0, 4'hF, 1'b1, 1'b1, 10'h155);
    check_pins(16'h8000);
    conv(1'b0, 1'b1, 4'h8, 1'b0, 1'b0, 10'h3FF);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`APC_ADDR_PIN_HIGH);
    chk16("upper after second reset", `APC_DATA_ZERO, rd_val);
    results();
  end
endmodule // apc_pin_ctrl_test
